// ===== verilog/sesr_core.sv
// Standard event status reporting core driven by common commands
//
// Overview of operation
// - Clear-status empties errors, idles completion tracking
// - Clear-status zeroes event registers, keeps enables
// - Enable mask is 0..255, resets to zero
// - Summary bit 5 ORs enabled event flags
// - Enable query returns mask unchanged
// - Event query returns flags, then clears them
// - Error class sets its own event bit
// - Current/voltage fault sets device error bit
// - Completion command zeroes bit 0, sets later
// - Completion command never stalls later commands
// - Completion query answers ASCII 0 or 1
// - Completion needs all three units idle
// - Wait command holds next command until idle
// - Identity reply has four comma-separated fields
// - Status bit 6 ORs service-enabled bits
`timescale 1ns/1ns
module sesr_core #(
  parameter int unsigned NUM_UNITS = 3,
  parameter int unsigned ERRQ_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic [sesr_pkg::CMD_W-1:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  input wire logic err_valid,
  input wire logic [2:0] err_class,
  input wire logic [NUM_UNITS-1:0] unit_busy,
  input wire logic [7:0] oper_evt_set,
  input wire logic [7:0] ques_evt_set,
  input wire logic msg_avail,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  output logic [7:0] status_byte,
  output logic [7:0] err_count
);
  import sesr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ese_q, ese_d;
  logic [7:0] sre_q, sre_d;
  logic [7:0] esr_q, esr_d;
  logic [7:0] oper_q, oper_d;
  logic [7:0] ques_q, ques_d;
  logic [7:0] errq_q, errq_d;
  logic [7:0] stb_q, stb_d;
  sesr_opc_e opc_q, opc_d;
  sesr_cmd_e st_q, st_d;
  logic rdy_q, rdy_d;
  logic rspv_q, rspv_d;
  logic [7:0] rspd_q, rspd_d;
  logic rspl_q, rspl_d;
  logic take;
  logic all_idle;
  logic opc_done;
  logic [7:0] esr_set;
  logic [7:0] sb_base;
  logic idn_start;
  logic idn_valid;
  logic [7:0] idn_data;
  logic idn_last;

  // Map an error class onto its event flag
  function automatic logic [7:0] class_bit(input logic vld, input logic [2:0] cls);
    class_bit = 8'h00;
    if (vld) begin
      case (cls)
        ERR_CMD: class_bit[EV_CMD] = 1'b1;
        ERR_EXE: class_bit[EV_EXE] = 1'b1;
        ERR_DEV: class_bit[EV_DEV] = 1'b1;
        ERR_QRY: class_bit[EV_QRY] = 1'b1;
        default: class_bit = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  // Commands are only taken while ready; the parser must wait otherwise
  assign take = cmd_valid && rdy_q;
  assign all_idle = (unit_busy == '0);
  // No completion in the cycle that re-arms, so bit 0 is seen low once
  assign opc_done = (opc_q == SESR_OPC_ARMED) && all_idle &&
                    !(take && cmd_code == CMD_OPC);
  always_comb begin
    esr_set = class_bit(err_valid, err_class);
    if (ques_evt_set[1:0] != 2'b00) begin
      esr_set[EV_DEV] = 1'b1;
    end
    if (opc_done) begin
      esr_set[EV_OPC] = 1'b1;
    end
  end

  // Status byte sources before the service summary
  always_comb begin
    sb_base = 8'h00;
    sb_base[SB_BUSY] = !all_idle;
    sb_base[SB_ERRQ] = (errq_q != 8'h00);
    sb_base[SB_QUES] = |ques_q;
    sb_base[SB_MAV] = msg_avail;
    sb_base[SB_ESB] = |(esr_q & ese_q);
    sb_base[SB_OPER] = |oper_q;
  end

  // ----------------------------------------------------------------
  // Command execution and register next values
  // ----------------------------------------------------------------
  // Clears are applied first and sets after, so a same-cycle event survives
  always_comb begin
    ese_d = ese_q;
    sre_d = sre_q;
    esr_d = esr_q;
    oper_d = oper_q;
    ques_d = ques_q;
    errq_d = errq_q;
    opc_d = opc_q;
    st_d = st_q;
    rdy_d = rdy_q;
    rspv_d = 1'b0;
    rspd_d = 8'h00;
    rspl_d = 1'b0;
    idn_start = 1'b0;
    if (take) begin
      case (cmd_code)
        CMD_CLS: begin
          esr_d = EVT_RST;
          oper_d = EVT_RST;
          ques_d = EVT_RST;
          errq_d = 8'h00;
          opc_d = SESR_OPC_IDLE;
        end
        CMD_ESE: ese_d = cmd_arg;
        CMD_ESE_Q: begin
          rspv_d = 1'b1;
          rspd_d = ese_q;
          rspl_d = 1'b1;
        end
        CMD_ESR_Q: begin
          rspv_d = 1'b1;
          rspd_d = esr_q;
          rspl_d = 1'b1;
          esr_d = EVT_RST;
        end
        CMD_OPC: begin
          esr_d[EV_OPC] = 1'b0;
          opc_d = SESR_OPC_ARMED;
        end
        CMD_OPC_Q: begin
          rspv_d = 1'b1;
          rspl_d = 1'b1;
          // Unarmed tracking answers one, which the host must not trust
          rspd_d = (opc_q == SESR_OPC_ARMED) ? ASCII_0 : ASCII_1;
        end
        CMD_WAI: begin
          if (!all_idle) begin
            st_d = SESR_WAIT;
            rdy_d = 1'b0;
          end
        end
        CMD_IDN_Q: begin
          idn_start = 1'b1;
          st_d = SESR_IDN;
          rdy_d = 1'b0;
        end
        CMD_SRE: sre_d = cmd_arg & SRE_WMASK;
        CMD_SRE_Q: begin
          rspv_d = 1'b1;
          rspd_d = sre_q;
          rspl_d = 1'b1;
        end
        CMD_STB_Q: begin
          rspv_d = 1'b1;
          rspd_d = stb_q;
          rspl_d = 1'b1;
        end
        default: begin
          rspv_d = 1'b0;
        end
      endcase
    end
    if (opc_done) begin
      opc_d = SESR_OPC_IDLE;
    end
    esr_d = (esr_d | esr_set) & EV_USED;
    oper_d = oper_d | oper_evt_set;
    ques_d = ques_d | ques_evt_set;
    if (err_valid && errq_d != 8'(ERRQ_DEPTH)) begin
      errq_d = errq_d + 8'h01;
    end
    // Hold-off and reply streaming
    case (st_q)
      SESR_WAIT: begin
        if (all_idle) begin
          st_d = SESR_RUN;
          rdy_d = 1'b1;
        end
      end
      SESR_IDN: begin
        rspv_d = idn_valid;
        rspd_d = idn_data;
        rspl_d = idn_last;
        if (idn_valid && idn_last) begin
          st_d = SESR_RUN;
          rdy_d = 1'b1;
        end
      end
      default: begin
        // Idle keeps the state a command chose; ready returns after reset
        if (st_d == SESR_RUN) begin
          rdy_d = 1'b1;
        end
      end
    endcase
  end

  // Status byte follows its sources one cycle later
  always_comb begin
    stb_d = sb_base;
    stb_d[SB_MSS] = |(sb_base & sre_q);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ese_q <= ESE_RST;
      sre_q <= SRE_RST;
      esr_q <= EVT_RST;
      oper_q <= EVT_RST;
      ques_q <= EVT_RST;
      errq_q <= 8'h00;
      stb_q <= 8'h00;
      opc_q <= SESR_OPC_IDLE;
      st_q <= SESR_RUN;
      rdy_q <= 1'b0;
      rspv_q <= 1'b0;
      rspd_q <= 8'h00;
      rspl_q <= 1'b0;
    end else begin
      ese_q <= ese_d;
      sre_q <= sre_d;
      esr_q <= esr_d;
      oper_q <= oper_d;
      ques_q <= ques_d;
      errq_q <= errq_d;
      stb_q <= stb_d;
      opc_q <= opc_d;
      st_q <= st_d;
      rdy_q <= rdy_d;
      rspv_q <= rspv_d;
      rspd_q <= rspd_d;
      rspl_q <= rspl_d;
    end
  end

  // Identity text generator; its output is re-registered above
  sesr_idn u_idn (
    .core_clk(core_clk),
    .srst(srst),
    .start(idn_start),
    .char_valid(idn_valid),
    .char_data(idn_data),
    .char_last(idn_last)
  );

  assign cmd_ready = rdy_q;
  assign rsp_valid = rspv_q;
  assign rsp_data = rspd_q;
  assign rsp_last = rspl_q;
  assign status_byte = stb_q;
  assign err_count = errq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_esb_summary: assert property (@(posedge core_clk) disable iff (srst)
    !$past(srst) |-> stb_q[SB_ESB] == $past(|(esr_q & ese_q)))
    else $error("event summary bit wrong");
  chk_unused_zero: assert property (@(posedge core_clk) disable iff (srst)
    (esr_q & ~EV_USED) == 8'h00)
    else $error("unused event bit set");
  chk_esr_readclr: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_ESR_Q |=> rsp_valid && rsp_data == $past(esr_q)
      && esr_q == ($past(esr_set) & EV_USED))
    else $error("event query did not read then clear");
  chk_ese_query: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_ESE_Q |=> rsp_data == $past(ese_q) && $stable(ese_q))
    else $error("enable query wrong");
  chk_cls_keeps: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_CLS |=> ques_q == $past(ques_evt_set) && $stable(ese_q)
      && $stable(sre_q) && opc_q == SESR_OPC_IDLE)
    else $error("clear-status wrong");
  chk_cls_errq: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_CLS && !err_valid |=> err_count == 8'h00)
    else $error("error queue not emptied");
  chk_err_class: assert property (@(posedge core_clk) disable iff (srst)
    err_valid && err_class == ERR_EXE |=> esr_q[EV_EXE])
    else $error("execution error not flagged");
  chk_fault_dev: assert property (@(posedge core_clk) disable iff (srst)
    ques_evt_set[1:0] != 2'b00 |=> esr_q[EV_DEV] ##1 status_byte[SB_QUES])
    else $error("fault did not flag device error");
  chk_opc_arm: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_OPC |=> !esr_q[EV_OPC] && cmd_ready)
    else $error("completion command wrong");
  chk_opc_busy: assert property (@(posedge core_clk) disable iff (srst)
    opc_q == SESR_OPC_ARMED && !all_idle && !esr_q[EV_OPC] |=> !esr_q[EV_OPC])
    else $error("completion flagged while busy");
  chk_opc_query: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_OPC_Q |=>
      rsp_data == ($past(opc_q == SESR_OPC_ARMED) ? ASCII_0 : ASCII_1))
    else $error("completion query answer wrong");
  chk_wai_hold: assert property (@(posedge core_clk) disable iff (srst)
    take && cmd_code == CMD_WAI && !all_idle |=> !cmd_ready)
    else $error("wait did not hold commands");
  chk_sticky_dev: assert property (@(posedge core_clk) disable iff (srst)
    esr_q[EV_DEV] && !(take && (cmd_code == CMD_ESR_Q || cmd_code == CMD_CLS))
      |=> esr_q[EV_DEV])
    else $error("event flag lost");
  chk_mss_sum: assert property (@(posedge core_clk) disable iff (srst)
    !$past(srst) |-> status_byte[SB_MSS] == $past(|(sb_base & sre_q)))
    else $error("service summary wrong");

endmodule

// ===== verilog/sesr_pkg.sv
// Shared constants and types for the standard event status block
package sesr_pkg;

  // ----------------------------------------------------------------
  // Command codes from the parser
  // ----------------------------------------------------------------
  localparam int unsigned CMD_W = 4;
  localparam logic [3:0] CMD_CLS = 4'h0;
  localparam logic [3:0] CMD_ESE = 4'h1;
  localparam logic [3:0] CMD_ESE_Q = 4'h2;
  localparam logic [3:0] CMD_ESR_Q = 4'h3;
  localparam logic [3:0] CMD_IDN_Q = 4'h4;
  localparam logic [3:0] CMD_OPC = 4'h5;
  localparam logic [3:0] CMD_OPC_Q = 4'h6;
  localparam logic [3:0] CMD_WAI = 4'h7;
  localparam logic [3:0] CMD_SRE = 4'h8;
  localparam logic [3:0] CMD_SRE_Q = 4'h9;
  localparam logic [3:0] CMD_STB_Q = 4'ha;

  // ----------------------------------------------------------------
  // Standard event flag positions
  // ----------------------------------------------------------------
  localparam int unsigned EV_OPC = 0;
  localparam int unsigned EV_QRY = 2;
  localparam int unsigned EV_DEV = 3;
  localparam int unsigned EV_EXE = 4;
  localparam int unsigned EV_CMD = 5;
  localparam logic [7:0] EV_USED = 8'h3d;

  // ----------------------------------------------------------------
  // Status byte positions
  // ----------------------------------------------------------------
  localparam int unsigned SB_BUSY = 0;
  localparam int unsigned SB_ERRQ = 2;
  localparam int unsigned SB_QUES = 3;
  localparam int unsigned SB_MAV = 4;
  localparam int unsigned SB_ESB = 5;
  localparam int unsigned SB_MSS = 6;
  localparam int unsigned SB_OPER = 7;
  localparam logic [7:0] SRE_WMASK = 8'hbf;

  // ----------------------------------------------------------------
  // Reset values, error classes, replies
  // ----------------------------------------------------------------
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [7:0] EVT_RST = 8'h00;
  localparam logic [2:0] ERR_CMD = 3'h1;
  localparam logic [2:0] ERR_EXE = 3'h2;
  localparam logic [2:0] ERR_DEV = 3'h3;
  localparam logic [2:0] ERR_QRY = 3'h4;
  localparam logic [7:0] ASCII_0 = 8'h30;
  localparam logic [7:0] ASCII_1 = 8'h31;

  typedef enum logic [1:0] {SESR_RUN, SESR_WAIT, SESR_IDN} sesr_cmd_e;
  typedef enum logic {SESR_OPC_IDLE, SESR_OPC_ARMED} sesr_opc_e;

endpackage

// ===== verilog/sesr_idn.sv
// Identification reply streamer, one character per clock
`timescale 1ns/1ns
module sesr_idn #(
  parameter int unsigned TEXT_LEN = 38,
  // Arbitrary neutral identification text
  parameter logic [8*TEXT_LEN-1:0] TEXT = "MAKER,MODEL 0-0 01/01/2000,000000,0.00"
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  output logic char_valid,
  output logic [7:0] char_data,
  output logic char_last
);
  import sesr_pkg::*;

  // ----------------------------------------------------------------
  // Character walk
  // ----------------------------------------------------------------
  logic [7:0] idx_q, idx_d;
  logic run_q, run_d;
  logic valid_q, valid_d;
  logic [7:0] data_q, data_d;
  logic last_q, last_d;

  // Pick one character, first character in the top byte
  function automatic logic [7:0] text_char(input logic [7:0] i);
    text_char = TEXT[8*(TEXT_LEN-1-int'(i)) +: 8];
  endfunction

  // Four comma-separated fields leave in order, no gaps
  always_comb begin
    idx_d = idx_q;
    run_d = run_q;
    valid_d = 1'b0;
    data_d = 8'h00;
    last_d = 1'b0;
    if (run_q) begin
      valid_d = 1'b1;
      data_d = text_char(idx_q);
      last_d = (idx_q == 8'(TEXT_LEN - 1));
      idx_d = idx_q + 8'h01;
      if (last_d) begin
        run_d = 1'b0;
        idx_d = 8'h00;
      end
    end else if (start) begin
      run_d = 1'b1;
      idx_d = 8'h00;
    end
  end

  // Registers only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      idx_q <= 8'h00;
      run_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= 8'h00;
      last_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      run_q <= run_d;
      valid_q <= valid_d;
      data_q <= data_d;
      last_q <= last_d;
    end
  end

  assign char_valid = valid_q;
  assign char_data = data_q;
  assign char_last = last_q;

endmodule

// ===== verif/sesr_host.sv
// Host controller model issuing common commands to the core
`timescale 1ns/1ns
module sesr_host
  import sesr_pkg::*;
(
  input wire logic core_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  output logic cmd_valid,
  output logic [sesr_pkg::CMD_W-1:0] cmd_code,
  output logic [7:0] cmd_arg
);
  logic [7:0] rsp_q[$];
  int last_at;

  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_arg = 8'h00;
    last_at = 0;
  end

  // Reply bytes stand one cycle, so take them at that edge
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      rsp_q.push_back(rsp_data);
      if (rsp_last === 1'b1) begin
        last_at = rsp_q.size();
      end
    end
  end

  // Strobe raised only once a falling edge sees ready, held one cycle; argument is 8 bits wide
  task automatic send(input logic [3:0] c, input logic [7:0] a);
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_arg = a;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~c; // Released lines show no stale value
    cmd_arg = ~a;
  endtask
endmodule

// ===== verif/sesr_core_tb.sv
// Self-checking bench for the standard event status core
`timescale 1ns/1ns
module sesr_core_tb;
  import sesr_pkg::*;
  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] arg;
    logic [3:0] qry;
    logic [7:0] exp;
  } sesr_row_s;
  logic core_clk;
  logic srst;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic [7:0] cmd_arg;
  logic err_valid;
  logic [2:0] err_class;
  logic [2:0] unit_busy;
  logic [7:0] oper_evt_set;
  logic [7:0] ques_evt_set;
  logic msg_avail;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  logic [7:0] status_byte;
  logic [7:0] err_count;
  int num_errors;
  int checks;
  int commas;
  sesr_row_s rows [5];

  sesr_core i_sesr_core (
    .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .err_valid(err_valid),
    .err_class(err_class), .unit_busy(unit_busy), .oper_evt_set(oper_evt_set),
    .ques_evt_set(ques_evt_set), .msg_avail(msg_avail), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .status_byte(status_byte), .err_count(err_count)
  );

  sesr_host i_sesr_host (
    .core_clk(core_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg)
  );

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Single-byte query; reply lands one cycle after the taking edge
  task automatic ask(input logic [3:0] c, input logic [7:0] exp);
    i_sesr_host.rsp_q.delete();
    i_sesr_host.send(c, 8'h00);
    @(negedge core_clk);
    check((i_sesr_host.rsp_q.size() == 1) ? i_sesr_host.rsp_q[0] : 8'hxx, exp);
  endtask

  // One-cycle event pulses
  task automatic ev(input logic e, input logic [2:0] c, input logic [7:0] q,
                    input logic [7:0] o);
    @(negedge core_clk);
    err_valid = e;
    err_class = c;
    ques_evt_set = q;
    oper_evt_set = o;
    @(negedge core_clk);
    err_valid = 1'b0;
    ques_evt_set = 8'h00;
    oper_evt_set = 8'h00;
  endtask

  // Status byte trails its sources by a cycle; give it a few
  task automatic sb(input logic [7:0] exp);
    repeat (3) @(negedge core_clk);
    check(status_byte, exp);
  endtask

  // Watchdog, run needs well under a thousand cycles
  initial begin
    #40000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    err_valid = 1'b0;
    err_class = 3'h0;
    unit_busy = 3'h0;
    oper_evt_set = 8'h00;
    ques_evt_set = 8'h00;
    msg_avail = 1'b0;
    rows[0] = '{CMD_ESE, 8'h3c, CMD_ESE_Q, 8'h3c};
    rows[1] = '{CMD_ESE, 8'hff, CMD_ESE_Q, 8'hff};
    rows[2] = '{CMD_SRE, 8'hff, CMD_SRE_Q, 8'hbf};
    rows[3] = '{CMD_SRE, 8'h28, CMD_SRE_Q, 8'h28};
    rows[4] = '{CMD_ESE, 8'h00, CMD_ESE_Q, 8'h00};
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    sb(8'h00);
    check(err_count, 8'h00);
    ask(CMD_ESE_Q, ESE_RST);
    ask(CMD_ESR_Q, 8'h00);
    foreach (rows[i]) begin
      i_sesr_host.send(rows[i].cmd, rows[i].arg);
      ask(rows[i].qry, rows[i].exp);
    end
    i_sesr_host.send(CMD_ESE, 8'h20);
    i_sesr_host.send(CMD_SRE, 8'h20);
    // Each error class lands on its own flag; read clears it
    for (int k = 1; k <= 4; k++) begin
      ev(1'b1, 3'(k), 8'h00, 8'h00);
      ask(CMD_ESR_Q, 8'h01 << (6 - k));
      ask(CMD_ESR_Q, 8'h00);
    end
    check(err_count, 8'h04);
    sb(8'h04);
    ev(1'b1, ERR_CMD, 8'h00, 8'h00);
    sb(8'h64);
    repeat (10) @(negedge core_clk);
    check(status_byte, 8'h64);
    ev(1'b0, 3'h0, 8'h01, 8'h01);
    msg_avail = 1'b1;
    sb(8'hfc);
    ask(CMD_STB_Q, 8'hfc);
    ask(CMD_ESR_Q, 8'h28);
    ev(1'b1, ERR_EXE, 8'h00, 8'h00);
    i_sesr_host.send(CMD_CLS, 8'h00);
    sb(8'h10);
    check(err_count, 8'h00);
    ask(CMD_ESR_Q, 8'h00);
    ask(CMD_ESE_Q, 8'h20);
    msg_avail = 1'b0;
    // Completion waits for every unit; queries keep flowing meanwhile
    unit_busy = 3'b110;
    i_sesr_host.send(CMD_OPC, 8'h00);
    ask(CMD_OPC_Q, ASCII_0);
    unit_busy = 3'b100;
    sb(8'h01);
    ask(CMD_OPC_Q, ASCII_0);
    unit_busy = 3'b000;
    sb(8'h00);
    ask(CMD_OPC_Q, ASCII_1);
    unit_busy = 3'b001;
    i_sesr_host.send(CMD_OPC, 8'h00);
    ask(CMD_ESR_Q, 8'h00);
    unit_busy = 3'b000;
    sb(8'h00);
    ask(CMD_ESR_Q, 8'h01);
    // Event in the very cycle of a read must survive the clear
    i_sesr_host.rsp_q.delete();
    fork
      ev(1'b1, ERR_EXE, 8'h00, 8'h00);
      i_sesr_host.send(CMD_ESR_Q, 8'h00);
    join
    @(negedge core_clk);
    check(i_sesr_host.rsp_q[0], 8'h00);
    ask(CMD_ESR_Q, 8'h10);
    // Hold-off after wait while a unit is busy
    unit_busy = 3'b010;
    i_sesr_host.send(CMD_WAI, 8'h00);
    repeat (5) @(negedge core_clk);
    check({7'h00, cmd_ready}, 8'h00);
    unit_busy = 3'b000;
    repeat (3) @(negedge core_clk);
    check({7'h00, cmd_ready}, 8'h01);
    // Identity text streams whole, last byte flagged
    i_sesr_host.rsp_q.delete();
    i_sesr_host.send(CMD_IDN_Q, 8'h00);
    repeat (45) @(negedge core_clk);
    commas = 0;
    foreach (i_sesr_host.rsp_q[i]) begin
      if (i_sesr_host.rsp_q[i] === 8'h2c) begin
        commas++;
      end
    end
    check(8'(i_sesr_host.rsp_q.size()), 8'h26);
    check(8'(commas), 8'h03);
    check(8'(i_sesr_host.last_at), 8'h26);
    // Mid-run reset must drop the mask written earlier
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    ask(CMD_ESE_Q, ESE_RST);
    sb(8'h00);
    give_verdict();
  end
endmodule
